// ===== adcc_pkg.sv
// Purpose: Shared constants and types of the ADC conversion control block
// Assumes: 32-bit classic Wishbone register bus, 10-bit SAR result
// Notes: Byte offsets are word aligned

package adcc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RES_W = 10;
    localparam int IDX_W = 4;
    localparam int CH_W = 3;
    localparam int DIV_W = 6;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RES_HIGH = 8'h04;
    localparam logic [7:0] OFF_RES_LOW = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;

    // ************************************************************
    // Control and status register fields
    // ************************************************************
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_CH_LSB = 2;
    localparam int CTRL_VREF_BIT = 5;
    localparam int CTRL_RJUST_BIT = 6;
    localparam int CTRL_CLK_LSB = 8;
    localparam int STAT_DONE_BIT = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [CH_W-1:0] CH_RST = 3'h0;
    localparam logic [1:0] CLK_RST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_TOP = 4'h9;

    // ************************************************************
    // Conversion clock dividers, last count of a bit period, one less than its cycles
    // ************************************************************
    localparam logic [DIV_W-1:0] DIV_SEL0 = 6'h01;
    localparam logic [DIV_W-1:0] DIV_SEL1 = 6'h07;
    localparam logic [DIV_W-1:0] DIV_SEL2 = 6'h1F;
    localparam logic [DIV_W-1:0] DIV_SEL3 = 6'h3F;

    // ************************************************************
    // Converter states
    // ************************************************************
    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_CONV = 3'b010,
        ADCC_DONE = 3'b100
    } adcc_state_t;

endpackage

// ===== adcc_conv_if.sv
// Purpose: Link between the register front end and the SAR engine
// Assumes: Single clock domain
// Notes: Analog pins are carried here as well

`timescale 1ns/1ps

interface adcc_conv_if;
    logic start;
    logic abort;
    logic tad_en;
    logic busy;
    logic done;
    logic [adcc_pkg::RES_W-1:0] result;
    logic [adcc_pkg::RES_W-1:0] dac_code;
    logic hold;
    logic cmp;

    modport ctrl (
        output start,
        output abort,
        output tad_en,
        output cmp,
        input busy,
        input done,
        input result,
        input dac_code,
        input hold
    );

    modport sar (
        input start,
        input abort,
        input tad_en,
        input cmp,
        output busy,
        output done,
        output result,
        output dac_code,
        output hold
    );
endinterface

// ===== adcc_sar.sv
// Purpose: Successive approximation engine, one bit per conversion clock
// Assumes: Comparator high when held input is at or above the trial code
// Notes: Result is valid from the done pulse until the next conversion completes

`timescale 1ns/1ps

module adcc_sar (
    input wire logic clk_i,
    input wire logic rst_i,
    adcc_conv_if.sar cv
);

    adcc_pkg::adcc_state_t state_q, state_d;
    logic [adcc_pkg::RES_W-1:0] code_q, code_d;
    logic [adcc_pkg::IDX_W-1:0] idx_q, idx_d;
    logic [adcc_pkg::RES_W-1:0] res_q, res_d;

    // Code with one bit forced to a value
    function automatic logic [adcc_pkg::RES_W-1:0] put_bit(
        input logic [adcc_pkg::RES_W-1:0] code,
        input logic [adcc_pkg::IDX_W-1:0] idx,
        input logic val);
        logic [adcc_pkg::RES_W-1:0] c;
        c = code;
        c[idx] = val;
        return c;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        code_d = code_q;
        idx_d = idx_q;
        res_d = res_q;
        case (state_q)
            adcc_pkg::ADCC_IDLE: begin
                if (cv.start) begin
                    state_d = adcc_pkg::ADCC_CONV;
                    idx_d = adcc_pkg::IDX_TOP;
                    code_d = put_bit(adcc_pkg::RES_RST, adcc_pkg::IDX_TOP, 1'b1);
                end
            end
            adcc_pkg::ADCC_CONV: begin
                if (cv.abort) begin
                    state_d = adcc_pkg::ADCC_IDLE;
                end else if (cv.tad_en) begin
                    // R9: decide one bit
                    code_d = put_bit(code_q, idx_q, cv.cmp);
                    if (idx_q == '0) begin
                        state_d = adcc_pkg::ADCC_DONE;
                        res_d = put_bit(code_q, idx_q, cv.cmp);
                    end else begin
                        idx_d = idx_q - 4'h1;
                        code_d = put_bit(put_bit(code_q, idx_q, cv.cmp), idx_q - 4'h1, 1'b1);
                    end
                end
            end
            adcc_pkg::ADCC_DONE: begin
                state_d = adcc_pkg::ADCC_IDLE;
            end
            default: begin
                state_d = adcc_pkg::ADCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= adcc_pkg::ADCC_IDLE;
            code_q <= adcc_pkg::RES_RST;
            idx_q <= adcc_pkg::IDX_TOP;
            res_q <= adcc_pkg::RES_RST;
        end else begin
            state_q <= state_d;
            code_q <= code_d;
            idx_q <= idx_d;
            res_q <= res_d;
        end
    end

    assign cv.busy = (state_q != adcc_pkg::ADCC_IDLE);
    assign cv.done = (state_q == adcc_pkg::ADCC_DONE);
    assign cv.hold = (state_q == adcc_pkg::ADCC_CONV);
    assign cv.dac_code = code_q;
    assign cv.result = res_q;

endmodule

// ===== adcc_top.sv
// Purpose: Register front end and control of a 10-bit SAR converter
// Assumes: Classic Wishbone slave, 32-bit data, synchronous reset
// Notes: Acquisition timing before start is left to software
//
// Summary of operation
// R1: Writing go while on starts a conversion
// R2: Go reads one until result is ready
// R3: Every conversion end sets complete flag
// R4: Software clears complete flag after reading result
// R5: Result registers are read-only to software
// R6: Software waits acquisition time before start
// R7: Right justify: high 2 bits, low 8
// R8: Software configures clock, reference, channel, format
// R9: Successive approximation yields 10-bit result
// R10: Module off: go ignored, results kept
//
// The placing of the registers and the Wishbone register port were decided locally.

`timescale 1ns/1ps

module adcc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmp_i,
    output logic [adcc_pkg::RES_W-1:0] dac_code_o,
    output logic hold_o,
    output logic [adcc_pkg::CH_W-1:0] chan_sel_o,
    output logic vref_ext_o,
    output logic adc_on_o,
    output logic irq_o
);

    adcc_conv_if cv ();

    // ************************************************************
    // State
    // ************************************************************
    logic on_q, on_d;
    logic [adcc_pkg::CH_W-1:0] ch_q, ch_d;
    logic vref_q, vref_d;
    logic rjust_q, rjust_d;
    logic [1:0] clk_sel_q, clk_sel_d;
    logic [adcc_pkg::RES_W-1:0] res_q, res_d;
    logic done_flag_q, done_flag_d;
    logic done_mask_q, done_mask_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [adcc_pkg::DIV_W-1:0] div_q, div_d;
    logic start;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] ctrl_word;
    logic [31:0] high_word;
    logic [31:0] low_word;

    // Bit period count for a clock select
    function automatic logic [adcc_pkg::DIV_W-1:0] div_limit(input logic [1:0] sel);
        case (sel)
            2'h0: return adcc_pkg::DIV_SEL0;
            2'h1: return adcc_pkg::DIV_SEL1;
            2'h2: return adcc_pkg::DIV_SEL2;
            default: return adcc_pkg::DIV_SEL3;
        endcase
    endfunction

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    // ************************************************************
    // Bus decode
    // ************************************************************
    // New access only on a fresh request, so ack drops after one cycle
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[adcc_pkg::CTRL_ON_BIT] = on_q;
        // R2: go reads busy
        ctrl_word[adcc_pkg::CTRL_GO_BIT] = cv.busy;
        ctrl_word[adcc_pkg::CTRL_CH_LSB +: adcc_pkg::CH_W] = ch_q;
        ctrl_word[adcc_pkg::CTRL_VREF_BIT] = vref_q;
        ctrl_word[adcc_pkg::CTRL_RJUST_BIT] = rjust_q;
        ctrl_word[adcc_pkg::CTRL_CLK_LSB +: 2] = clk_sel_q;
    end

    // R7: justification applied on read
    always_comb begin
        high_word = 32'h0000_0000;
        low_word = 32'h0000_0000;
        if (rjust_q) begin
            high_word[1:0] = res_q[9:8];
            low_word[7:0] = res_q[7:0];
        end else begin
            high_word[7:0] = res_q[9:2];
            low_word[7:6] = res_q[1:0];
        end
    end

    // ************************************************************
    // Registers and bus answer
    // ************************************************************
    always_comb begin
        logic [31:0] cw;
        cw = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
        on_d = on_q;
        ch_d = ch_q;
        vref_d = vref_q;
        rjust_d = rjust_q;
        clk_sel_d = clk_sel_q;
        done_mask_d = done_mask_q;
        start = 1'b0;
        ack_d = acc;
        rdat_d = rdat_q;
        if (wr) begin
            case (wb_adr_i)
                adcc_pkg::OFF_CTRL: begin
                    on_d = cw[adcc_pkg::CTRL_ON_BIT];
                    // Channel, reference and clock select frozen mid-conversion to keep the SAR coherent
                    if (!cv.busy) begin
                        ch_d = cw[adcc_pkg::CTRL_CH_LSB +: adcc_pkg::CH_W];
                        vref_d = cw[adcc_pkg::CTRL_VREF_BIT];
                        clk_sel_d = cw[adcc_pkg::CTRL_CLK_LSB +: 2];
                    end
                    rjust_d = cw[adcc_pkg::CTRL_RJUST_BIT];
                    // R1: go while on starts; R10: off blocks it
                    start = cw[adcc_pkg::CTRL_GO_BIT] & cw[adcc_pkg::CTRL_ON_BIT] & on_q & ~cv.busy;
                end
                adcc_pkg::OFF_MASK: begin
                    if (wb_sel_i[0]) begin
                        done_mask_d = wb_dat_i[adcc_pkg::STAT_DONE_BIT];
                    end
                end
                // R5: result offsets take no write
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (wb_adr_i)
                adcc_pkg::OFF_CTRL: rdat_d = ctrl_word;
                adcc_pkg::OFF_RES_HIGH: rdat_d = high_word;
                adcc_pkg::OFF_RES_LOW: rdat_d = low_word;
                adcc_pkg::OFF_STATUS: rdat_d = {31'h0000_0000, done_flag_q};
                adcc_pkg::OFF_MASK: rdat_d = {31'h0000_0000, done_mask_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Completion, result capture, flag
    // ************************************************************
    always_comb begin
        res_d = res_q;
        done_flag_d = done_flag_q;
        // R4: flag leaves only through a status read
        if (rd && wb_adr_i == adcc_pkg::OFF_STATUS) begin
            done_flag_d = 1'b0;
        end
        if (cv.done) begin
            // R9: store result
            res_d = cv.result;
            // R3: set wins over read-clear
            done_flag_d = 1'b1;
        end
    end

    // ************************************************************
    // Conversion clock divider
    // ************************************************************
    always_comb begin
        div_d = div_q;
        cv.tad_en = 1'b0;
        if (!cv.busy) begin
            div_d = '0;
        end else if (div_q == div_limit(clk_sel_q)) begin
            div_d = '0;
            cv.tad_en = 1'b1;
        end else begin
            div_d = div_q + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_q <= 1'b0;
            ch_q <= adcc_pkg::CH_RST;
            vref_q <= 1'b0;
            rjust_q <= 1'b0;
            clk_sel_q <= adcc_pkg::CLK_RST;
            res_q <= adcc_pkg::RES_RST;
            done_flag_q <= 1'b0;
            done_mask_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            div_q <= '0;
        end else begin
            on_q <= on_d;
            ch_q <= ch_d;
            vref_q <= vref_d;
            rjust_q <= rjust_d;
            clk_sel_q <= clk_sel_d;
            res_q <= res_d;
            done_flag_q <= done_flag_d;
            done_mask_q <= done_mask_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            div_q <= div_d;
        end
    end

    // ************************************************************
    // Engine and pins
    // ************************************************************
    assign cv.start = start;
    // R10: switching off aborts, result kept
    assign cv.abort = ~on_q;
    assign cv.cmp = cmp_i;

    adcc_sar u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cv(cv)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign dac_code_o = cv.dac_code;
    assign hold_o = cv.hold;
    assign chan_sel_o = ch_q;
    assign vref_ext_o = vref_q;
    assign adc_on_o = on_q;
    assign irq_o = done_flag_q & done_mask_q;

endmodule

// ===== adcc_ana_model.sv
// Purpose: Analog inputs behind a sample-and-hold, with comparator
// Assumes: Eight channel levels handed in packed, 10 bits each
// Notes: Input tracked while not holding

`timescale 1ns/1ps

module adcc_ana_model (
    input wire logic clk_i,
    input wire logic hold_i,
    input wire logic [adcc_pkg::RES_W-1:0] dac_i,
    input wire logic [adcc_pkg::CH_W-1:0] chan_i,
    input wire logic [79:0] lvl_i,
    output logic cmp_o
);
    logic [adcc_pkg::RES_W-1:0] held_q;
    always_ff @(posedge clk_i) begin
        if (!hold_i) begin
            held_q <= lvl_i[chan_i*10 +: 10];
        end
    end
    assign cmp_o = (held_q >= dac_i);
endmodule

// ===== adcc_top_sva.sv
// Purpose: Port level checks of the converter control
// Assumes: Busy bit covers the hold time and the one done cycle after it
// Notes: Mask is internal, so irq is judged by the bench

`timescale 1ns/1ps

module adcc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [adcc_pkg::RES_W-1:0] dac_code_o,
    input wire logic hold_o,
    input wire logic [adcc_pkg::CH_W-1:0] chan_sel_o,
    input wire logic vref_ext_o,
    input wire logic adc_on_o
);
    localparam int MAX_HOLD = 642;
    logic take;
    logic [9:0] cnt_q;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Slowest divider bounds the hold length
    always_ff @(posedge clk_i) begin
        if (rst_i || !hold_o) cnt_q <= 10'h000;
        else cnt_q <= cnt_q + 10'h001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    property p_start;
        take && wb_we_i && wb_adr_i == adcc_pkg::OFF_CTRL && wb_sel_i[0] && wb_dat_i[1:0] == 2'b11
            && adc_on_o && !hold_o && !$past(hold_o) |=> hold_o;
    endproperty
    a_start: assert property (p_start) else $error("go did not start");
    property p_dac; $rose(hold_o) |-> dac_code_o == 10'h200; endproperty
    a_dac: assert property (p_dac) else $error("first trial code wrong");
    property p_dur; cnt_q <= MAX_HOLD; endproperty
    a_dur: assert property (p_dur) else $error("conversion too long");
    property p_rdbusy;
        take && !wb_we_i && wb_adr_i == adcc_pkg::OFF_CTRL |=>
            wb_dat_o[1] == ($past(hold_o) || ($past(hold_o, 2) && $past(adc_on_o, 2)));
    endproperty
    a_rdbusy: assert property (p_rdbusy) else $error("busy bit wrong");
    property p_off; !adc_on_o |=> !$rose(hold_o); endproperty
    a_off: assert property (p_off) else $error("start while off");
    property p_chan; hold_o && $past(hold_o) |-> $stable(chan_sel_o) && $stable(vref_ext_o); endproperty
    a_chan: assert property (p_chan) else $error("setup changed while busy");
endmodule

bind adcc_top adcc_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dac_code_o(dac_code_o), .hold_o(hold_o), .chan_sel_o(chan_sel_o),
    .vref_ext_o(vref_ext_o), .adc_on_o(adc_on_o));

// ===== adcc_top_tb_top.sv
// Purpose: Self-checking bench of the converter control
// Assumes: Classic Wishbone, one cycle answer
// Notes: Rows cover every clock select

`timescale 1ns/1ps

module adcc_top_tb_top;
    typedef struct packed {logic [2:0] ch; logic [1:0] ck; logic rj; logic vr; logic mk;} adcc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd, q, cw;
    logic ack, cmp, hold, von, vref, irq;
    logic [9:0] dac, v;
    logic [2:0] ch;
    logic [79:0] lvl = {10'h3FE, 10'h001, 10'h1FF, 10'h200, 10'h15A, 10'h2A5, 10'h3FF, 10'h000};
    int err_total = 0;
    int tests_run = 0;
    int cyc_n = 0;
    int n;
    adcc_row_t rows [5] = '{'{3'h2, 2'h0, 1'b1, 1'b0, 1'b1}, '{3'h7, 2'h3, 1'b0, 1'b1, 1'b1},
        '{3'h0, 2'h1, 1'b1, 1'b1, 1'b0}, '{3'h1, 2'h2, 1'b0, 1'b0, 1'b1}, '{3'h3, 2'h0, 1'b1, 1'b0, 1'b0}};
    adcc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .cmp_i(cmp), .dac_code_o(dac),
        .hold_o(hold), .chan_sel_o(ch), .vref_ext_o(vref), .adc_on_o(von), .irq_o(irq));
    adcc_ana_model model_u (.clk_i(clk_i), .hold_i(hold), .dac_i(dac), .chan_i(ch), .lvl_i(lvl), .cmp_o(cmp));
    task give_verdict;
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            err_total++;
        end
    endtask
    // Holds the request until ack is sampled high
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        k = 0;
        do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
        if (k >= 50) err_total++;
        r = rd;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 10000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            acc(1'b0, 8'(k * 4), 32'h0, q);
            chk("reset", 32'h0, q);
        end
        foreach (rows[i]) begin
            cw = {22'h0, rows[i].ck, 1'b0, rows[i].rj, rows[i].vr, rows[i].ch, 2'b01};
            v = lvl[rows[i].ch*10 +: 10];
            acc(1'b1, adcc_pkg::OFF_MASK, {31'h0, rows[i].mk}, q);
            acc(1'b1, adcc_pkg::OFF_CTRL, cw, q);
            chk("cfg", {27'h0, rows[i].ch, rows[i].vr, 1'b1}, {27'h0, ch, vref, von});
            repeat (4) @(posedge clk_i);
            acc(1'b1, adcc_pkg::OFF_CTRL, cw | 32'h2, q);
            acc(1'b0, adcc_pkg::OFF_CTRL, 32'h0, q);
            chk("busy", 32'h1, {31'h0, q[1]});
            n = 0;
            while (q[1] !== 1'b0 && n < 300) begin
                acc(1'b0, adcc_pkg::OFF_CTRL, 32'h0, q);
                n++;
            end
            chk("done", cw, q);
            chk("irq", {31'h0, rows[i].mk}, {31'h0, irq});
            acc(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
            chk("flag", 32'h1, q);
            chk("irq clear", 32'h0, {31'h0, irq});
            acc(1'b0, adcc_pkg::OFF_RES_HIGH, 32'h0, q);
            chk("high", rows[i].rj ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, q);
            acc(1'b0, adcc_pkg::OFF_RES_LOW, 32'h0, q);
            chk("low", rows[i].rj ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, q);
        end
        acc(1'b1, adcc_pkg::OFF_RES_HIGH, 32'hFFFFFFFF, q);
        acc(1'b1, adcc_pkg::OFF_RES_LOW, 32'hFFFFFFFF, q);
        acc(1'b0, adcc_pkg::OFF_RES_LOW, 32'h0, q);
        chk("ro low", 32'h5A, q);
        acc(1'b0, adcc_pkg::OFF_RES_HIGH, 32'h0, q);
        chk("ro high", 32'h1, q);
        acc(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        // Abort mid-conversion, then go in the write that turns on
        acc(1'b1, adcc_pkg::OFF_CTRL, 32'h341, q);
        acc(1'b1, adcc_pkg::OFF_CTRL, 32'h343, q);
        repeat (20) @(posedge clk_i);
        acc(1'b1, adcc_pkg::OFF_CTRL, 32'h340, q);
        acc(1'b0, adcc_pkg::OFF_CTRL, 32'h0, q);
        chk("abort", 32'h340, q);
        acc(1'b1, adcc_pkg::OFF_CTRL, 32'h343, q);
        repeat (30) @(posedge clk_i);
        acc(1'b0, adcc_pkg::OFF_CTRL, 32'h0, q);
        chk("go ignored", 32'h341, q);
        acc(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
        chk("no flag", 32'h0, q);
        acc(1'b0, adcc_pkg::OFF_RES_LOW, 32'h0, q);
        chk("kept low", 32'h5A, q);
        // Reset in the middle of a conversion
        acc(1'b1, adcc_pkg::OFF_CTRL, 32'h343, q);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("rst pins", 32'h0, {16'h0, dac, ch, hold, von, irq});
        acc(1'b0, adcc_pkg::OFF_CTRL, 32'h0, q);
        chk("rst ctrl", 32'h0, q);
        acc(1'b0, adcc_pkg::OFF_RES_LOW, 32'h0, q);
        chk("rst low", 32'h0, q);
        acc(1'b0, adcc_pkg::OFF_STATUS, 32'h0, q);
        chk("rst flag", 32'h0, q);
        give_verdict();
    end
endmodule
